// file: crc_consts.svh
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

// Generator polynomials, top term implied, MSB-first form
`define CRC_POLY_CCITT   32'h0000_1021
`define CRC_POLY_16      32'h0000_8005
`define CRC_POLY_32      32'h04C1_1DB7

// Accumulator width masks
`define CRC_MASK_16      32'h0000_FFFF
`define CRC_MASK_32      32'hFFFF_FFFF

// Accumulator reset value
`define CRC_RESET_SEED   32'h0000_0000

// Top bit of the accumulator per width
`define CRC_TOP_16       15
`define CRC_TOP_32       31

// Data path geometry
`define CRC_DATA_W       32
`define CRC_SIZE_W       2
`define CRC_FIFO_DEPTH   16

// Bytes consumed per write size
`define CRC_BYTES_BYTE   3'h1
`define CRC_BYTES_HALF   3'h2
`define CRC_BYTES_WORD   3'h4

`endif

// file: crc_pkg.sv
package crc_pkg;

   // Polynomial selection on poly_sel_i
   typedef enum logic [1:0] {
      POLY_CCITT,
      POLY_CRC16,
      POLY_CRC32
   } poly_sel_t;

   // Width of one data write on wr_size_i
   typedef enum logic [1:0] {
      SIZE_BYTE,
      SIZE_HALF,
      SIZE_WORD
   } wsize_t;

endpackage : crc_pkg

// file: crc_fifo.sv
// Show-ahead FIFO: head word always sits in a register, the rest in an
// array. Total capacity is DEPTH words.
module crc_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int PW = $clog2(DEPTH);

   // Power of two keeps pointer wrap free of compare logic
   if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_geom
      $error("crc_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
   logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
   logic [PW:0]      cnt_reg, cnt_next;
   logic             head_valid_reg, head_valid_next;
   logic [WIDTH-1:0] head_reg, head_next;
   logic             ready_reg, ready_next;
   logic             push, pop, mem_we;

   // Head refill takes from the array first, else bypasses the input
   always_comb begin
      push            = in_valid_i && ready_reg;
      pop             = head_valid_reg && out_ready_i;
      wr_ptr_next     = wr_ptr_reg;
      rd_ptr_next     = rd_ptr_reg;
      cnt_next        = cnt_reg;
      head_valid_next = head_valid_reg;
      head_next       = head_reg;
      mem_we          = 1'b0;
      if (!head_valid_reg || pop) begin
         if (cnt_reg != '0) begin
            head_next       = mem[rd_ptr_reg];
            head_valid_next = 1'b1;
            rd_ptr_next     = rd_ptr_reg + 1'b1;
            cnt_next        = cnt_next - 1'b1;
            mem_we          = push;
         end else begin
            head_next       = in_data_i;
            head_valid_next = push;
         end
      end else begin
         mem_we = push;
      end
      if (mem_we) begin
         wr_ptr_next = wr_ptr_reg + 1'b1;
         cnt_next    = cnt_next + 1'b1;
      end
      // Full counts the head word too, so the source feels back-pressure
      ready_next = ({1'b0, cnt_next} + {{(PW+1){1'b0}}, head_valid_next})
                   < (PW+2)'(DEPTH);
   end

   // State registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr_reg     <= '0;
         rd_ptr_reg     <= '0;
         cnt_reg        <= '0;
         head_valid_reg <= 1'b0;
         head_reg       <= '0;
         ready_reg      <= 1'b1;
      end else begin
         wr_ptr_reg     <= wr_ptr_next;
         rd_ptr_reg     <= rd_ptr_next;
         cnt_reg        <= cnt_next;
         head_valid_reg <= head_valid_next;
         head_reg       <= head_next;
         ready_reg      <= ready_next;
      end
   end

   // Storage array, no reset needed
   always_ff @(posedge clk_i) begin
      if (mem_we)
         mem[wr_ptr_reg] <= in_data_i;
   end

   assign in_ready_o  = ready_reg;
   assign out_valid_o = head_valid_reg;
   assign out_data_o  = head_reg;

endmodule : crc_fifo

// file: crc_engine.sv
// Notes on behaviour
// (RULE_01) CCITT setting divides by x^16 + x^12 + x^5 + 1.
// (RULE_02) CRC-16 setting divides by x^16 + x^15 + x^2 + 1.
// (RULE_03) CRC-32 setting uses the standard 32-bit generator.
// (RULE_04) Input bytes may be bit-reversed and inverted, each independently.
// (RULE_05) Result may be bit-reversed and inverted on read, each independently.
// (RULE_06) Software loads a seed into the accumulator before a calculation.
// (RULE_07) Processor or DMA writes arrive back to back without software help.
// (RULE_08) A byte write is absorbed in one clock cycle.
// (RULE_09) A halfword write is two bytes over two cycles.
// (RULE_10) A word write is four bytes over four cycles.
// (RULE_11) Writes and result reads stall by ready while bytes are pending; writes stall here only once the FIFO is full.
// (RULE_12) Seed load resets accumulator at once; bytes consumed LSB first.
`include "crc_consts.svh"

module crc_engine
   import crc_pkg::*;
#(
   parameter int FIFO_DEPTH = `CRC_FIFO_DEPTH
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // Configuration
   input  wire logic [1:0]  poly_sel_i,
   input  wire logic        in_rev_i,
   input  wire logic        in_inv_i,
   input  wire logic        out_rev_i,
   input  wire logic        out_inv_i,
   input  wire logic [31:0] seed_i,
   input  wire logic        seed_load_i,
   // Data writes
   input  wire logic        wr_valid_i,
   output logic             wr_ready_o,
   input  wire logic [31:0] wr_data_i,
   input  wire logic [1:0]  wr_size_i,
   // Result reads
   input  wire logic        rd_req_i,
   output logic             rd_ready_o,
   output logic [31:0]      result_o,
   output logic             result_valid_o,
   output logic             busy_o
);
   localparam int FW = `CRC_SIZE_W + `CRC_DATA_W;

   // Fewer than two words would serialise every DMA burst
   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("crc_engine: FIFO_DEPTH must be at least 2");
   end

   // Bit reversal of one byte
   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
         r[i] = b[7-i];
      return r;
   endfunction : rev8

   // Bit reversal of a full word
   function automatic logic [31:0] rev32(input logic [31:0] w);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++)
         r[i] = w[31-i];
      return r;
   endfunction : rev32

   // Generator value of the selected setting
   function automatic logic [31:0] poly_of(input poly_sel_t p);
      logic [31:0] g;
      g = `CRC_POLY_32;                                // RULE_03
      case (p)
         POLY_CCITT: g = `CRC_POLY_CCITT;              // RULE_01
         POLY_CRC16: g = `CRC_POLY_16;                 // RULE_02
         default:    g = `CRC_POLY_32;                 // RULE_03
      endcase
      return g;
   endfunction : poly_of

   // Width mask of the selected setting
   function automatic logic [31:0] mask_of(input poly_sel_t p);
      logic [31:0] m;
      m = (p == POLY_CCITT || p == POLY_CRC16) ? `CRC_MASK_16
                                                : `CRC_MASK_32;
      return m;
   endfunction : mask_of

   // One byte through the divider, MSB first, eight shifts unrolled
   function automatic logic [31:0] crc_step(input logic [31:0] c,
                                            input logic [7:0]  d,
                                            input poly_sel_t   p);
      logic [31:0] r;
      logic [31:0] g;
      logic        fb;
      r  = c;
      g  = poly_of(p);
      fb = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         fb = d[i] ^ ((p == POLY_CRC32) ? r[`CRC_TOP_32] : r[`CRC_TOP_16]);
         r  = {r[30:0], 1'b0} ^ (fb ? g : 32'h0000_0000);
      end
      return r & mask_of(p);
   endfunction : crc_step

   // Byte counts per write size; an undefined size code acts as a word
   function automatic logic [2:0] bytes_of(input logic [1:0] s);
      logic [2:0] n;
      case (s)
         SIZE_BYTE: n = `CRC_BYTES_BYTE;               // RULE_08
         SIZE_HALF: n = `CRC_BYTES_HALF;               // RULE_09
         default:   n = `CRC_BYTES_WORD;               // RULE_10
      endcase
      return n;
   endfunction : bytes_of

   poly_sel_t       poly;
   logic            f_valid;
   logic            f_ready;
   logic [FW-1:0]   f_data;
   logic            f_in_ready;

   logic [31:0]     crc_reg, crc_next;
   logic [31:0]     word_reg, word_next;
   logic [2:0]      cnt_reg, cnt_next;
   logic            rd_ready_reg, rd_ready_next;
   logic [31:0]     result_reg, result_next;
   logic            rvalid_reg, rvalid_next;
   logic            busy_reg, busy_next;

   logic            proc_en;
   logic [7:0]      byte_eff;
   logic [31:0]     sum_view;

   // Undefined selector code falls back to the 32-bit setting
   assign poly = (poly_sel_i == 2'h3) ? POLY_CRC32 : poly_sel_t'(poly_sel_i);

   // Writes queue here so DMA bursts wait on the divider only once the FIFO is full
   crc_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (wr_valid_i),
      .in_ready_o  (f_in_ready),
      .in_data_i   ({wr_size_i, wr_data_i}),
      .out_valid_o (f_valid),
      .out_ready_i (f_ready),
      .out_data_o  (f_data)
   );

   // Write ready is the FIFO's registered room flag
   assign wr_ready_o = f_in_ready;                     // RULE_07

   // Current byte after the input options
   always_comb begin
      byte_eff = word_reg[7:0];
      if (in_rev_i)
         byte_eff = rev8(byte_eff);                    // RULE_04
      if (in_inv_i)
         byte_eff = ~byte_eff;                         // RULE_04
   end

   // Accumulator as presented to the reader
   always_comb begin
      sum_view = crc_reg & mask_of(poly);
      if (out_rev_i) begin
         sum_view = rev32(sum_view);                   // RULE_05
         if (poly != POLY_CRC32)
            sum_view = sum_view >> 16;
      end
      if (out_inv_i)
         sum_view = sum_view ^ mask_of(poly);          // RULE_05
   end

   // Byte engine: a seed load wins the cycle and holds the byte stream,
   // so no pending byte is dropped; the next word is taken while the last
   // byte of the current one is processed, giving one byte every cycle.
   always_comb begin
      crc_next  = crc_reg;
      word_next = word_reg;
      cnt_next  = cnt_reg;
      proc_en   = 1'b0;
      f_ready   = 1'b0;
      if (seed_load_i) begin
         crc_next = seed_i & mask_of(poly);            // RULE_06 RULE_12
      end else begin
         if (cnt_reg != 3'h0) begin
            proc_en   = 1'b1;
            crc_next  = crc_step(crc_reg, byte_eff, poly);
            word_next = {8'h00, word_reg[31:8]};       // RULE_12
            cnt_next  = cnt_reg - 3'h1;
         end
         // Refill only once the current word is on its last byte or none is left
         f_ready = (cnt_reg <= 3'h1);                  // RULE_11
         if (f_ready && f_valid) begin
            word_next = f_data[31:0];
            cnt_next  = bytes_of(f_data[FW-1:32]);     // RULE_08 RULE_09 RULE_10
         end
      end
   end

   // Read side: answers only when nothing is queued or in flight
   always_comb begin
      rd_ready_next = (cnt_next == 3'h0) && !f_valid &&
                      !(wr_valid_i && f_in_ready) && !seed_load_i; // RULE_11
      busy_next     = (cnt_next != 3'h0) || f_valid ||
                      (wr_valid_i && f_in_ready);
      rvalid_next   = rd_req_i && rd_ready_reg;
      result_next   = result_reg;
      if (rd_req_i && rd_ready_reg)
         result_next = sum_view;                       // RULE_05
   end

   // State registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         crc_reg      <= `CRC_RESET_SEED;
         word_reg     <= 32'h0000_0000;
         cnt_reg      <= 3'h0;
         rd_ready_reg <= 1'b0;
         result_reg   <= 32'h0000_0000;
         rvalid_reg   <= 1'b0;
         busy_reg     <= 1'b0;
      end else begin
         crc_reg      <= crc_next;
         word_reg     <= word_next;
         cnt_reg      <= cnt_next;
         rd_ready_reg <= rd_ready_next;
         result_reg   <= result_next;
         rvalid_reg   <= rvalid_next;
         busy_reg     <= busy_next;
      end
   end

   assign rd_ready_o     = rd_ready_reg;
   assign result_o       = result_reg;
   assign result_valid_o = rvalid_reg;
   assign busy_o         = busy_reg;

   // Checks on the divider and the byte sequencing
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   a_ccitt_gen: assert property ( // RULE_01
      (proc_en && !seed_load_i && poly == POLY_CCITT &&
       crc_reg == 32'h0000_0000 && byte_eff == 8'h01)
      |=> crc_reg == 32'h0000_1021)
      else $error("CCITT step gave wrong remainder");

   a_crc16_gen: assert property ( // RULE_02
      (proc_en && !seed_load_i && poly == POLY_CRC16 &&
       crc_reg == 32'h0000_0000 && byte_eff == 8'h01)
      |=> crc_reg == 32'h0000_8005)
      else $error("CRC-16 step gave wrong remainder");

   a_crc32_gen: assert property ( // RULE_03
      (proc_en && !seed_load_i && poly == POLY_CRC32 &&
       crc_reg == 32'h0000_0000 && byte_eff == 8'h01)
      |=> crc_reg == 32'h04C1_1DB7)
      else $error("CRC-32 step gave wrong remainder");

   a_input_invert: assert property ( // RULE_04
      (proc_en && in_inv_i && !in_rev_i)
      |=> crc_reg == crc_step($past(crc_reg), ~$past(word_reg[7:0]),
                              $past(poly)))
      else $error("Input byte not inverted before division");

   a_result_invert: assert property ( // RULE_05
      (rd_req_i && rd_ready_o && out_inv_i && !out_rev_i &&
       poly == POLY_CRC32)
      |=> result_valid_o && result_o == ~$past(crc_reg))
      else $error("Result not inverted on read");

   a_seed_load: assert property ( // RULE_06
      (seed_load_i && poly == POLY_CRC32) |=> crc_reg == $past(seed_i))
      else $error("Seed not loaded into accumulator");

   a_byte_one: assert property ( // RULE_08
      (f_valid && f_ready && f_data[FW-1:32] == SIZE_BYTE)
      |=> cnt_reg == 3'h1)
      else $error("Byte write not scheduled for one cycle");

   a_half_two: assert property ( // RULE_09
      (f_valid && f_ready && f_data[FW-1:32] == SIZE_HALF)
      ##1 !seed_load_i [*2]
      |=> $past(cnt_reg) == 3'h1 && (cnt_reg == 3'h0 || $past(f_valid)))
      else $error("Halfword write not done in two cycles");

   a_word_four: assert property ( // RULE_10
      (f_valid && f_ready && f_data[FW-1:32] == SIZE_WORD)
      |=> cnt_reg == 3'h4 ##1 ($past(seed_load_i) || cnt_reg == 3'h3))
      else $error("Word write not sequenced over four cycles");

   a_stall_busy: assert property ( // RULE_11
      (cnt_reg > 3'h1) |-> !f_ready ##1 !rd_ready_o)
      else $error("New word or read taken while bytes pending");

   a_lsb_first: assert property ( // RULE_12
      (proc_en && !seed_load_i && cnt_reg > 3'h1)
      |=> word_reg[23:0] == $past(word_reg[31:8]))
      else $error("Bytes not consumed least significant first");

endmodule : crc_engine

// file: crc_bus_master.sv
// Processor or DMA side of the write port: holds each write until taken
module crc_bus_master (
   input  wire logic        clk_i,
   input  wire logic        wr_ready_i,
   output logic             wr_valid_o,
   output logic [31:0]      wr_data_o,
   output logic [1:0]       wr_size_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle strobe at time zero
   initial begin
      wr_valid_o = 1'b0;
      wr_data_o  = 32'h0000_0000;
      wr_size_o  = 2'h0;
   end

   // Strobe stays up across back-to-back calls, so DMA bursts need no gap
   task automatic put(input logic [31:0] data, input logic [1:0] size,
                      output bit ok);
      wr_valid_o = 1'b1;
      wr_data_o  = data;
      wr_size_o  = size;
      ok = 1'b0;
      for (int w = 0; w < 200 && !ok; w++) begin
         @(posedge clk_i);
         ok = (wr_ready_i === 1'b1);
      end
      #1;
   endtask : put

   // Released data lines flip each cycle so a stale word is never reused
   task automatic idle(input int cycles);
      wr_valid_o = 1'b0;
      repeat (cycles) begin
         wr_data_o = ~wr_data_o;
         @(posedge clk_i);
         #1;
      end
   endtask : idle
endmodule : crc_bus_master

// file: crc_engine_tb.sv
module crc_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [1:0]  poly = 2'h0;
   logic        irev = 1'b0;
   logic        iinv = 1'b0;
   logic        orev = 1'b0;
   logic        oinv = 1'b0;
   logic [31:0] seed_v = 32'h0000_0000;
   logic        seed_ld = 1'b0;
   logic        rd_req = 1'b0;
   logic        wr_valid;
   logic        wr_ready;
   logic [31:0] wr_data;
   logic [1:0]  wr_size;
   logic        rd_ready;
   logic [31:0] result;
   logic        result_valid;
   logic        busy;
   logic [31:0] acc = 32'h0000_0000;
   logic [31:0] exp_q[$];
   bit          ok;
   bit          stalled = 1'b0;
   int          n_mismatch = 0;
   int          checked = 0;
   int          cycles = 0;
   // Check values of the string 123456789 for the three settings
   localparam logic [31:0] kv_exp[3] = '{32'h0000_29B1, 32'h0000_BB3D,
                                         32'hCBF4_3926};
   localparam logic [31:0] kv_seed[3] = '{32'h0000_FFFF, 32'h0000_0000,
                                          32'hFFFF_FFFF};
   localparam logic [2:0]  kv_opt[3] = '{3'h0, 3'h6, 3'h7};
   // Byte 01 into a zero accumulator leaves the generator itself
   localparam logic [31:0] kv_gen[3] = '{32'h0000_1021, 32'h0000_8005,
                                         32'h04C1_1DB7};

   always #5 clk = ~clk;

   crc_engine #(.FIFO_DEPTH(16)) dut (
      .clk_i(clk), .resetn_i(resetn), .poly_sel_i(poly),
      .in_rev_i(irev), .in_inv_i(iinv), .out_rev_i(orev),
      .out_inv_i(oinv), .seed_i(seed_v), .seed_load_i(seed_ld),
      .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_data_i(wr_data),
      .wr_size_i(wr_size), .rd_req_i(rd_req), .rd_ready_o(rd_ready),
      .result_o(result), .result_valid_o(result_valid), .busy_o(busy)
   );

   crc_bus_master master (
      .clk_i(clk), .wr_ready_i(wr_ready), .wr_valid_o(wr_valid),
      .wr_data_o(wr_data), .wr_size_o(wr_size)
   );

   function automatic int wid();
      return (poly < 2'h2) ? 16 : 32;
   endfunction : wid

   function automatic logic [31:0] rev(input logic [31:0] v, input int w);
      logic [31:0] r;
      r = 32'h0000_0000;
      for (int i = 0; i < w; i++) r[i] = v[w-1-i];
      return r;
   endfunction : rev

   // Reference division, MSB first; options applied as in the hand-over
   function automatic logic [31:0] step(input logic [31:0] a,
                                        input logic [7:0] b);
      logic [31:0] p;
      logic [31:0] t;
      logic        fb;
      p = (poly == 2'h0) ? 32'h0000_1021 :
          (poly == 2'h1) ? 32'h0000_8005 : 32'h04C1_1DB7;
      t = irev ? rev({24'h0, b}, 8) : {24'h0, b};
      t = iinv ? ~t : t;
      for (int i = 7; i >= 0; i--) begin
         fb = a[wid()-1] ^ t[i];
         a  = a << 1;
         if (fb) a = a ^ p;
      end
      return (wid() == 16) ? (a & 32'h0000_FFFF) : a;
   endfunction : step

   function automatic logic [31:0] view(input logic [31:0] a);
      a = orev ? rev(a, wid()) : a;
      a = oinv ? ~a : a;
      return (wid() == 16) ? (a & 32'h0000_FFFF) : a;
   endfunction : view

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic conclude();
      $display("Counts: %0d checked, %0d mismatches", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // Model folds bytes in before the write is issued, low byte first
   task automatic wr(input logic [31:0] d, input logic [1:0] s);
      int nb;
      nb = (s == 2'h0) ? 1 : (s == 2'h1) ? 2 : 4;
      for (int i = 0; i < nb; i++) acc = step(acc, d[8*i +: 8]);
      master.put(d, s, ok);
      if (!ok) chk("write accept", 32'h1, 32'h0);
   endtask : wr

   // Only called while idle: queued words would follow the new seed
   task automatic load(input logic [31:0] v);
      seed_v  = v;
      seed_ld = 1'b1;
      acc = (poly < 2'h2) ? (v & 32'h0000_FFFF) : v;
      @(posedge clk);
      #1;
      seed_ld = 1'b0;
   endtask : load

   // One edge of rest after each read keeps the strobe from double reads
   task automatic rd(input logic [31:0] e);
      rd_req = 1'b1;
      exp_q.push_back(e);
      ok = 1'b0;
      for (int w = 0; w < 200 && !ok; w++) begin
         @(posedge clk);
         ok = (rd_ready === 1'b1);
      end
      #1;
      rd_req = 1'b0;
      if (!ok) chk("read accept", 32'h1, 32'h0);
      @(posedge clk);
      #1;
   endtask : rd

   // Scoreboard and watchdog; a result pulse retires the oldest note
   always @(posedge clk) begin
      cycles++;
      if (wr_valid && wr_ready !== 1'b1) stalled = 1'b1;
      if (result_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("stray result", 32'h0, 32'h1);
         else chk("result", exp_q.pop_front(), result);
      end
      if (cycles == 30000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      int t[3];
      int n;
      int g;
      int s;
      s = $urandom(17);
      repeat (20) @(posedge clk);
      #1;
      resetn = 1'b1;
      chk("busy after reset", 32'h0, {31'h0, busy});
      chk("ready after reset", 32'h1, {31'h0, wr_ready});
      // Time to idle per write size; differences avoid fixed pipe delay
      poly = 2'h2;
      load(32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
         wr(32'h1234_5678 + 32'(k), 2'(k));
         master.idle(0);
         chk("busy while queued", 32'h1, {31'h0, busy});
         t[k] = 0;
         do begin
            @(posedge clk);
            t[k]++;
         end while (rd_ready !== 1'b1 && t[k] < 100);
         #1;
         chk("busy when idle", 32'h0, {31'h0, busy});
      end
      chk("half minus byte", 32'h1, 32'(t[1] - t[0]));
      chk("word minus byte", 32'h3, 32'(t[2] - t[0]));
      rd(view(acc));
      $display("test sizes done");
      for (int k = 0; k < 3; k++) begin
         poly = 2'(k);
         load(32'h0000_0000);
         wr(32'h0000_0001, 2'h0);
         master.idle(1);
         rd(kv_gen[k]);
      end
      $display("test generators done");
      for (int k = 0; k < 3; k++) begin
         poly = 2'(k);
         iinv = 1'b0;
         {irev, orev, oinv} = kv_opt[k];
         load(kv_seed[k]);
         for (int c = 0; c < 9; c++) wr(32'h31 + 32'(c), 2'h0);
         master.idle(1);
         rd(kv_exp[k]);
      end
      $display("test check values done");
      // Each seed load also discards the last run's remainder
      for (int m = 0; m < 64; m++) begin
         poly = m[1:0];
         {irev, iinv, orev, oinv} = m[5:2];
         load($urandom());
         n = $urandom_range(6, 1);
         for (int j = 0; j < n; j++) begin
            wr($urandom(), 2'($urandom_range(3, 0)));
            g = $urandom_range(2, 0);
            if (g != 0) master.idle(g);
         end
         master.idle(1);
         rd(view(acc));
      end
      $display("test modes done");
      // Word burst outruns the byte engine, so the queue must push back
      poly = 2'h2;
      stalled = 1'b0;
      load(32'hFFFF_FFFF);
      for (int j = 0; j < 40; j++) wr($urandom(), 2'h2);
      master.idle(1);
      chk("write stall seen", 32'h1, {31'h0, stalled});
      rd(view(acc));
      $display("test burst done");
      conclude();
   end
endmodule : crc_engine_tb
